//--- rtl/memory_bus_release_pkg.sv
// Purpose: shared constants and types of the memory bus release block
// Assumes: clk_sys is the CPU clock; memory-port clock is clk_sys / MEM_DIV
// Notes:   times are kept in their own unit (ns, us, E or P periods), counts derive
package memory_bus_release_pkg;

    // ==========================================================
    // clocking (ns, us) and pin timing, in P (cpu) and E (memory) periods
    // ==========================================================
    localparam int CLK_PERIOD_NS   = 5;
    localparam int MEM_DIV_DEFAULT = 4;
    localparam int E_FLOAT_MIN     = 2;
    localparam int E_RESUME_MIN    = 2;
    localparam int E_RESUME_MAX    = 7;
    localparam int E_ZV_MIN        = 16;
    localparam int E_ZV_MAX        = 20;
    localparam int P_ZV_MAX        = 3;
    localparam int P_HOST_MIN      = 2;
    localparam int P_HOST_MAX      = 6;
    localparam int P_LOW_MAX       = 6;
    localparam int P_BOOT_HOLD     = 4;
    localparam int P_RESET_MIN     = 10;
    localparam int PLL_SETTLE_US   = 250;
    localparam int HOST_START_CNT  = (P_HOST_MIN + P_HOST_MAX) / 2;
    localparam int LOW_START_CNT   = P_LOW_MAX / 2;

    // ==========================================================
    // register map
    // ==========================================================
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int CTRL_INHIBIT_BIT    = 0;
    localparam int CTRL_FSEL_LSB       = 1;
    localparam int STAT_GRANT_BIT      = 0;
    localparam int STAT_DRIVE_BIT      = 1;
    localparam int STAT_PEND_BIT       = 2;
    localparam int STAT_BUSY_BIT       = 3;
    localparam int STAT_BOOT_LSB       = 16;
    localparam logic       INHIBIT_RST = 1'b0;
    localparam logic [1:0] FSEL_RST    = 2'h0;
    localparam int BOOT_W              = 11;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_DRAIN,
        ST_FLOATED,
        ST_GRANTED,
        ST_RESUME
    } hold_st_t;

endpackage : memory_bus_release_pkg

//--- rtl/pin_sync3.sv
// Purpose: three-stage synchroniser for pins from outside clk_sys
// Assumes: input may change at any time
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    // no reset: a pipeline of samples, level valid four edges after power-up
    always_comb begin
        s_d     = s_q;
        s_d.s1  = pin_in;
        s_d.s2  = s_q.s1;
        s_d.s3  = s_q.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.lvl[i] = s_q.s2[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    assign level = s_q.lvl;

endmodule : pin_sync3

//--- rtl/memory_bus_release_reset.sv
// Purpose: bus release handshake and reset-time pin control of a memory port
// Assumes: AHB-Lite slave, zero wait states; mem_busy from the port logic
// Notes:   E period is MEM_DIV cycles of clk_sys; P period is one cycle
//
// Overview of operation
// - finish in-flight memory accesses before floating the bus and granting.
// - keep bus driven at least two memory periods after request falls.
// - grant goes low within two memory periods after bus floats.
// - bus driven again two to seven memory periods after request rises.
// - grant returns high within two memory periods after bus drives.
// - while release is inhibited, no grant; requests wait forever (inhibit is checked only in ST_RUN; a release already under way still grants).
// - per-clock select: 0 keeps clock toggling, 1 floats it in release.
// - floated clocks follow the same two and seven period windows.
// - pending-access flag changes only on rising edge of clock one.
// - boot pins sampled at reset release, stable four cpu periods around.
// - in reset, second-port address pins and host pin are boot inputs.
// - memory pins float in reset, driven 16E to 3P+20E after release.
// - in reset grant follows request; pending flag held low.
// - memory clock one floats in reset, valid by 3P+20E after release.
// - host and serial floating group driven two to six cpu periods later.
// - low group valid within six cpu periods after release.
// - eeprom pins in low group only if host-bus set and serial2 clear.
`timescale 1ns/1ps
module memory_bus_release_reset
    import memory_bus_release_pkg::*;
#(
    parameter int MEM_DIV = MEM_DIV_DEFAULT
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [31:0]       hrdata,
    input  wire logic              release_req_n,
    input  wire logic              mem_busy,
    input  wire logic              host_bus_select,
    input  wire logic              serial2_select,
    input  wire logic [BOOT_W-1:0] boot_cfg_pins,
    output logic                   bus_release_grant_n,
    output logic                   access_block,
    output logic                   bus_oe,
    output logic                   boot_pins_oe,
    output logic      [1:0]        memory_clock_output,
    output logic      [1:0]        memory_clock_oe,
    output logic                   pending_access_flag,
    output logic                   host_group_oe,
    output logic                   low_group_valid,
    output logic                   eeprom_low_group,
    output logic                   eeprom_oe,
    output logic      [BOOT_W-1:0] boot_cfg
);

    // ==========================================================
    // derived counts
    // ==========================================================
    localparam int DW        = $clog2(MEM_DIV);
    localparam int TWO_E     = E_FLOAT_MIN * MEM_DIV;
    localparam int SEVEN_E   = E_RESUME_MAX * MEM_DIV;
    localparam logic [DW-1:0] DIV_MAX  = DW'(MEM_DIV - 1);
    localparam logic [DW-1:0] DIV_HALF = DW'(MEM_DIV / 2);
    localparam logic [7:0] FLOAT_CNT  = 8'(E_FLOAT_MIN * MEM_DIV);
    localparam logic [7:0] RESUME_CNT = 8'(E_RESUME_MIN * MEM_DIV);
    localparam logic [7:0] BUS_START  = 8'(E_ZV_MIN * MEM_DIV);
    localparam logic [7:0] CLK_START  = 8'(E_FLOAT_MIN * MEM_DIV);
    localparam logic [7:0] HOST_START = 8'(HOST_START_CNT);
    localparam logic [7:0] LOW_START  = 8'(LOW_START_CNT);

    typedef struct packed {
        hold_st_t          st;
        logic [7:0]        cnt;
        logic              drive;
        logic              bus_oe;
        logic              grant_n;
        logic              block;
        logic [DW-1:0]     div;
        logic [1:0]        clk_out;
        logic [1:0]        clk_oe;
        logic              pending;
        logic [7:0]        post;
        logic              boot_done;
        logic [BOOT_W-1:0] boot_cfg;
        logic              boot_oe;
        logic              host_oe;
        logic              low_valid;
        logic              eeprom_low;
        logic              eeprom_oe;
        logic              inhibit;
        logic [1:0]        float_sel;
        logic              wr_pend;
        logic [7:0]        waddr;
        logic [31:0]       rdata;
        logic              hready;
        logic [5:0]        low_cnt;
        logic [5:0]        high_cnt;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic              req_lvl;
    logic [1:0]        sel_lvl;
    logic [BOOT_W-1:0] boot_lvl;

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    pin_sync3 #(.WIDTH(1)) u_req_sync (
        .clk_sys (clk_sys),
        .pin_in  (release_req_n),
        .level   (req_lvl)
    );

    pin_sync3 #(.WIDTH(2)) u_sel_sync (
        .clk_sys (clk_sys),
        .pin_in  ({host_bus_select, serial2_select}),
        .level   (sel_lvl)
    );

    pin_sync3 #(.WIDTH(BOOT_W)) u_boot_sync (
        .clk_sys (clk_sys),
        .pin_in  (boot_cfg_pins),
        .level   (boot_lvl)
    );

    // ==========================================================
    // register access helpers
    // ==========================================================
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    function automatic logic [31:0] read_word(input logic [7:0] a,
                                              input state_t     v);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (reg_hit(a, ADDR_CTRL)) begin
            w[CTRL_INHIBIT_BIT]            = v.inhibit;
            w[CTRL_FSEL_LSB +: 2]          = v.float_sel;
        end else if (reg_hit(a, ADDR_STATUS)) begin
            w[STAT_GRANT_BIT]              = ~v.grant_n;
            w[STAT_DRIVE_BIT]              = v.bus_oe;
            w[STAT_PEND_BIT]               = v.pending;
            w[STAT_BUSY_BIT]               = (v.st != ST_RUN);
            w[STAT_BOOT_LSB +: BOOT_W]     = v.boot_cfg;
        end
        read_word = w;
    endfunction : read_word

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        logic tick;
        logic bus_ok;
        logic clk_ok;
        logic eep;
        tick   = 1'b0;
        bus_ok = 1'b0;
        clk_ok = 1'b0;
        eep    = 1'b0;
        s_d    = s_q;

        // memory clock divider; rise when the count wraps to zero
        tick      = (s_q.div == DIV_MAX);
        s_d.div   = tick ? '0 : s_q.div + 1'b1;
        s_d.clk_out = {2{s_d.div < DIV_HALF}};
        if (tick) begin
            s_d.pending = mem_busy;
        end

        // time since reset release, saturating
        if (s_q.post != 8'hFF) begin
            s_d.post = s_q.post + 8'h01;
        end
        bus_ok = (s_q.post >= BUS_START);
        clk_ok = (s_q.post >= CLK_START);
        s_d.host_oe   = (s_q.post >= HOST_START);
        s_d.low_valid = (s_q.post >= LOW_START);

        eep = sel_lvl[1] & ~sel_lvl[0];
        s_d.eeprom_low = eep;
        s_d.eeprom_oe  = eep ? s_d.low_valid : s_d.host_oe;

        // boot straps taken once, on the first edge out of reset
        if (!s_q.boot_done) begin
            s_d.boot_done = 1'b1;
            s_d.boot_cfg  = boot_lvl;
        end

        // consecutive request level, for the timing checks
        if (req_lvl) begin
            s_d.low_cnt = '0;
            if (s_q.high_cnt != 6'h3F) begin
                s_d.high_cnt = s_q.high_cnt + 6'h01;
            end
        end else begin
            s_d.high_cnt = '0;
            if (s_q.low_cnt != 6'h3F) begin
                s_d.low_cnt = s_q.low_cnt + 6'h01;
            end
        end

        // release handshake
        case (s_q.st)
            ST_RUN: begin
                if (!req_lvl && !s_q.inhibit) begin
                    s_d.st    = ST_DRAIN;
                    s_d.cnt   = '0;
                    s_d.block = 1'b1;
                end
            end
            ST_DRAIN: begin
                if (s_q.cnt != 8'hFF) begin
                    s_d.cnt = s_q.cnt + 8'h01;
                end
                if (req_lvl) begin
                    s_d.st    = ST_RUN;
                    s_d.block = 1'b0;
                end else if (!mem_busy && s_q.cnt >= FLOAT_CNT) begin
                    s_d.drive = 1'b0;
                    s_d.st    = ST_FLOATED;
                end
            end
            ST_FLOATED: begin
                if (!s_q.bus_oe) begin
                    s_d.grant_n = 1'b0;
                    s_d.st      = ST_GRANTED;
                    s_d.cnt     = '0;
                end
            end
            ST_GRANTED: begin
                // a master that rises early still gets the full minimum
                s_d.cnt = req_lvl ? s_q.cnt + 8'h01 : 8'h00;
                if (req_lvl && s_q.cnt >= RESUME_CNT) begin
                    s_d.drive = 1'b1;
                    s_d.st    = ST_RESUME;
                end
            end
            ST_RESUME: begin
                if (s_q.bus_oe || !bus_ok) begin
                    s_d.grant_n = 1'b1;
                    s_d.st      = ST_RUN;
                    s_d.block   = 1'b0;
                end
            end
            default: begin
                s_d.st = ST_RUN;
            end
        endcase

        s_d.bus_oe  = s_q.drive & bus_ok;
        s_d.boot_oe = s_q.drive & bus_ok;
        for (int i = 0; i < 2; i++) begin
            s_d.clk_oe[i] = clk_ok &
                            ~(~s_q.drive & s_q.float_sel[i]);
        end

        // AHB-Lite: data phase write, then the new address phase
        s_d.hready = 1'b1;
        if (s_q.wr_pend && reg_hit(s_q.waddr, ADDR_CTRL)) begin
            s_d.inhibit   = hwdata[CTRL_INHIBIT_BIT];
            s_d.float_sel = hwdata[CTRL_FSEL_LSB +: 2];
        end
        s_d.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            if (hwrite) begin
                s_d.wr_pend = 1'b1;
                s_d.waddr   = haddr[7:0];
            end else begin
                // read from the updated copy so write-then-read is coherent
                s_d.rdata = read_word(haddr[7:0], s_d);
            end
        end

        if (!reset_n) begin
            s_d            = '0;
            s_d.st         = req_lvl ? ST_RUN : ST_GRANTED;
            s_d.drive      = req_lvl;
            s_d.grant_n    = req_lvl;
            s_d.inhibit    = INHIBIT_RST;
            s_d.float_sel  = FSEL_RST;
            s_d.hready     = 1'b1;
            s_d.boot_cfg   = s_q.boot_cfg;
            s_d.eeprom_low = eep;
            s_d.eeprom_oe  = eep;
            s_d.boot_oe    = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign hreadyout           = s_q.hready;
    assign hresp               = 1'b0;
    assign hrdata              = s_q.rdata;
    assign bus_release_grant_n = s_q.grant_n;
    assign access_block        = s_q.block;
    assign bus_oe              = s_q.bus_oe;
    assign boot_pins_oe        = s_q.boot_oe;
    assign memory_clock_output = s_q.clk_out;
    assign memory_clock_oe     = s_q.clk_oe;
    assign pending_access_flag = s_q.pending;
    assign host_group_oe       = s_q.host_oe;
    assign low_group_valid     = s_q.low_valid;
    assign eeprom_low_group    = s_q.eeprom_low;
    assign eeprom_oe           = s_q.eeprom_oe;
    assign boot_cfg            = s_q.boot_cfg;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    chk_drain_idle: assert property (
        $fell(s_q.drive) |-> !$past(mem_busy))
        else $error("bus floated with an access in flight");

    chk_float_after_low: assert property (
        $fell(s_q.bus_oe) |-> s_q.low_cnt >= TWO_E)
        else $error("bus floated too soon after request");

    chk_ack_after_float: assert property (
        $fell(s_q.bus_oe) |-> ##[1:TWO_E] !s_q.grant_n)
        else $error("grant late after float");

    chk_resume_window: assert property (
        $rose(s_q.bus_oe) && !s_q.grant_n |->
            s_q.high_cnt >= TWO_E && s_q.high_cnt <= SEVEN_E)
        else $error("bus resumed outside window");

    chk_ack_release: assert property (
        $rose(s_q.bus_oe) && !s_q.grant_n |-> ##[1:TWO_E] s_q.grant_n)
        else $error("grant not withdrawn after resume");

    chk_inhibit_hold: assert property (
        s_q.inhibit && s_q.st == ST_RUN |=> s_q.st == ST_RUN)
        else $error("release started while inhibited");

    chk_clk_float_sel: assert property (
        !s_q.drive && s_q.float_sel[0] |=> !s_q.clk_oe[0])
        else $error("clock one driven while float selected");

    chk_clk_keep_run: assert property (
        !s_q.drive && !s_q.float_sel[1] && s_q.post >= CLK_START
            |=> s_q.clk_oe[1])
        else $error("clock two floated while keep selected");

    chk_pending_edge: assert property (
        $changed(s_q.pending) |-> s_q.div == '0 && s_q.clk_out[0])
        else $error("pending flag moved off clock edge");

    chk_host_window: assert property (
        $rose(s_q.host_oe) |->
            s_q.post >= P_HOST_MIN && s_q.post <= P_HOST_MAX)
        else $error("host group driven outside window");

    // split by level: the synchroniser is unknown for its first edges
    chk_reset_grant_hi: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        !reset_n && !$past(reset_n) && $past(req_lvl) |-> s_q.grant_n)
        else $error("grant low in reset with request high");

    chk_reset_grant_lo: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        !reset_n && !$past(reset_n) && !$past(req_lvl) |-> !s_q.grant_n)
        else $error("grant high in reset with request low");

endmodule : memory_bus_release_reset

//--- verif/bus_master_model.sv
// Purpose: outside master that asks the memory port for its bus
// Assumes: want_bus comes from the bench; request pin is active low
// Notes:   request moves only just after a rising edge of clk_sys
`timescale 1ns/1ps
module bus_master_model #(
    parameter int MEM_DIV = 4
) (
    input  wire logic clk_sys,
    input  wire logic want_bus,
    input  wire logic bus_release_grant_n,
    output logic      release_req_n
);
    int held;

    initial begin
        release_req_n = 1'b1;
        held          = 0;
    end

    // ==========================================================
    // request pin
    // ==========================================================
    // a refused request may be dropped at once; a granted one is
    // kept at least one memory period past the grant
    always @(posedge clk_sys) begin
        held <= bus_release_grant_n ? 0 : held + 1;
        if (want_bus)
            release_req_n <= 1'b0;
        else if (bus_release_grant_n || held >= MEM_DIV)
            release_req_n <= 1'b1;
    end
endmodule : bus_master_model

//--- verif/memory_bus_release_reset_bench.sv
// Purpose: self-checking bench of the bus release and reset pin block
// Assumes: one AHB-Lite slave, its hreadyout is the bus hready
// Notes:   all times are counted in clk_sys cycles; E is MEM_DIV cycles
`timescale 1ns/1ps
module memory_bus_release_reset_bench;
    import memory_bus_release_pkg::*;
    localparam int E = 4;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
    } row_t;
    // status read-only, ctrl bits, reserved bits, unmapped, inhibit, cleared
    localparam row_t ROWS [6] = '{
        '{32'h0000_0004, 32'hFFFF_FFFF, 32'h05A3_0002},
        '{32'h0000_0000, 32'h0000_0006, 32'h0000_0006},
        '{32'h0000_0000, 32'hFFFF_FFF8, 32'h0000_0000},
        '{32'h0000_0008, 32'h0000_005A, 32'h0000_0000},
        '{32'h0000_0000, 32'h0000_0001, 32'h0000_0001},
        '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000}};

    logic              clk_sys, reset_n, hsel, hwrite, want, mem_busy;
    logic              host_bus_select, serial2_select, pend_prev;
    logic [31:0]       haddr, hwdata, hrdata, rd;
    logic [1:0]        htrans, memory_clock_output, memory_clock_oe;
    logic [2:0]        hsize;
    logic [BOOT_W-1:0] boot_cfg_pins, boot_cfg;
    logic              hreadyout, hresp, release_req_n, bus_release_grant_n;
    logic              access_block, bus_oe, boot_pins_oe, eeprom_oe;
    logic              pending_access_flag, host_group_oe, low_group_valid;
    logic              eeprom_low_group, c;
    logic [5:0]        mon;
    int                fail_count, cmp_count, n, t;

    assign mon = {release_req_n, low_group_valid, host_group_oe,
                  memory_clock_oe[0], bus_release_grant_n, bus_oe};

    memory_bus_release_reset #(.MEM_DIV(E)) memory_bus_release_reset_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .release_req_n(release_req_n), .mem_busy(mem_busy),
        .host_bus_select(host_bus_select), .serial2_select(serial2_select),
        .boot_cfg_pins(boot_cfg_pins),
        .bus_release_grant_n(bus_release_grant_n),
        .access_block(access_block), .bus_oe(bus_oe),
        .boot_pins_oe(boot_pins_oe),
        .memory_clock_output(memory_clock_output),
        .memory_clock_oe(memory_clock_oe),
        .pending_access_flag(pending_access_flag),
        .host_group_oe(host_group_oe), .low_group_valid(low_group_valid),
        .eeprom_low_group(eeprom_low_group), .eeprom_oe(eeprom_oe),
        .boot_cfg(boot_cfg));

    bus_master_model #(.MEM_DIV(E)) bus_master_model_inst (
        .clk_sys(clk_sys), .want_bus(want),
        .bus_release_grant_n(bus_release_grant_n),
        .release_req_n(release_req_n));

    // ==========================================================
    // helpers
    // ==========================================================
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic rng(input int v, input int lo, input int hi);
        cmp_count++;
        if (v < lo || v > hi) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, v, lo);
        end
    endtask : rng

    // cycles until a watched signal reaches lvl, capped at 400 cycles
    task automatic measure(input int idx, input logic lvl, output int k);
        k = 0;
        while (mon[idx] !== lvl && k < 400) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
    endtask : measure

    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        r = hrdata;
    endtask : ahb

    // ==========================================================
    // clock, watchdog, pending flag monitor
    // ==========================================================
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        fail_count++;
        finish_test();
    end

    always @(negedge clk_sys) begin
        if (reset_n === 1'b1 && pending_access_flag !== pend_prev)
            check(memory_clock_output[0], 1'b1);
        pend_prev = pending_access_flag;
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        {reset_n, hsel, hwrite, want, mem_busy, serial2_select} = '0;
        {haddr, hwdata, htrans, pend_prev, fail_count, cmp_count} = '0;
        hsize           = 3'h2;
        host_bus_select = 1'b1;
        boot_cfg_pins   = 11'h5A3;
        // power-up hold long enough for a multiplied clock to settle
        repeat (PLL_SETTLE_US * 1000 / CLK_PERIOD_NS)
            @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            {host_bus_select, serial2_select} <= 2'(i);
            repeat (8) @(posedge clk_sys);
            #1;
            check(eeprom_low_group, 32'(i == 2));
            check(eeprom_oe, 32'(i == 2));
        end
        @(posedge clk_sys);
        serial2_select <= 1'b0;
        want           <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        check(bus_release_grant_n, 1'b0);
        @(posedge clk_sys);
        want <= 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        check(bus_release_grant_n, 1'b1);
        check({bus_oe, boot_pins_oe, memory_clock_oe, pending_access_flag,
               host_group_oe, low_group_valid}, 0);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        t = 0;
        measure(4, 1'b1, n);
        t += n;
        rng(t, 0, 6);
        measure(3, 1'b1, n);
        t += n;
        rng(t, 2, 6);
        measure(2, 1'b1, n);
        t += n;
        rng(t, 0, 3 + 20 * E);
        measure(0, 1'b1, n);
        t += n;
        rng(t, 16 * E, 3 + 20 * E);
        check(boot_cfg, 11'h5A3);
        check({boot_pins_oe, eeprom_oe}, 2'b11);
        @(posedge clk_sys);
        boot_cfg_pins <= 11'h2AA;
        foreach (ROWS[i]) begin
            ahb(1'b1, ROWS[i].addr, ROWS[i].wdata, rd);
            ahb(1'b0, ROWS[i].addr, 32'h0, rd);
            check(rd, ROWS[i].rexp);
            check(hresp, 1'b0);
        end
        // handshake with clocks kept running, then with clocks floated
        for (int fs = 0; fs < 2; fs++) begin
            ahb(1'b1, 32'h0, fs ? 32'h6 : 32'h0, rd);
            @(posedge clk_sys);
            want <= 1'b1;
            measure(5, 1'b0, n);
            measure(0, 1'b0, n);
            rng(n, 2 * E, 5 * E);
            measure(1, 1'b0, n);
            rng(n, 0, 2 * E);
            check({access_block, memory_clock_oe},
                  fs ? 3'b100 : 3'b111);
            c = memory_clock_output[0];
            repeat (E / 2) @(posedge clk_sys);
            #1;
            if (fs == 0)
                check(memory_clock_output[0], !c);
            @(posedge clk_sys);
            want <= 1'b0;
            measure(5, 1'b1, n);
            measure(0, 1'b1, n);
            rng(n, 2 * E, 7 * E);
            check(memory_clock_oe, 2'b11);
            measure(1, 1'b1, n);
            rng(n, 0, 2 * E);
            check(access_block, 1'b0);
        end
        // access in flight holds off the grant
        @(posedge clk_sys);
        mem_busy <= 1'b1;
        want     <= 1'b1;
        repeat (10 * E) @(posedge clk_sys);
        #1;
        check({access_block, bus_oe, bus_release_grant_n,
               pending_access_flag}, 4'hF);
        @(posedge clk_sys);
        mem_busy <= 1'b0;
        measure(1, 1'b0, n);
        rng(n, 1, 5 * E);
        @(posedge clk_sys);
        want <= 1'b0;
        measure(1, 1'b1, n);
        // inhibited release never grants
        ahb(1'b1, 32'h0, 32'h1, rd);
        @(posedge clk_sys);
        want <= 1'b1;
        repeat (15 * E) @(posedge clk_sys);
        #1;
        check({bus_oe, bus_release_grant_n}, 2'b11);
        @(posedge clk_sys);
        want <= 1'b0;
        ahb(1'b1, 32'h0, 32'h0, rd);
        repeat (2 * E) @(posedge clk_sys);
        finish_test();
    end
endmodule : memory_bus_release_reset_bench
